// ### bench/irqr_status_bank_props.sv
/*
  Port-level checker of the raw status bank.
  Assumes a bind from the bench and the register map header.
*/
`timescale 1ns/10ps
`include "irqr_map.svh"

module irqr_status_bank_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire irqr_pkg::irqr_src_s src
);
  import irqr_pkg::*;
  logic [1:0] quiet_r;
  logic [1:0] quiet_nxt;
  irqr_src_s srcPrev_r;
  logic [13:0] idx;
  logic rd;
  logic calm;
  logic dmaAll;
  assign idx = paddr[15:2];
  assign rd = psel && penable && !pwrite && paddr[1:0] == 2'h0;
  assign calm = rd && quiet_r == 2'h3 && src == srcPrev_r;
  assign dmaAll = ((src.wdmaEnable & ~src.wdmaFilled) == 8'h0) && ((src.rdmaEnable & ~src.rdmaEmptied) == 8'h0)
    && (|(src.wdmaEnable | src.rdmaEnable));
  // Counts how long the sources have been still, so reads are judged only on settled data.
  always_comb begin
    quiet_nxt = (src != srcPrev_r) ? 2'h0 : (quiet_r == 2'h3) ? quiet_r : quiet_r + 2'h1;
  end
  always_ff @(posedge clk) begin
    quiet_r <= rst_n ? quiet_nxt : 2'h0;
    srcPrev_r <= src;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ------
  // Assertions
  // ------
  a_reset_clears: assert property ($rose(rst_n) |-> prdata == 32'h0 && !pslverr)
    else $error("read data not clear after reset");
  a_short_map: assert property (calm && idx == `IRQR_IDX_SHORT
    |-> prdata == {22'h0, src.shortDetect[7:6], 2'h0, src.shortDetect[5:0]}) else $error("short flags wrong");
  a_seq_busy: assert property (calm && idx == `IRQR_IDX_ON_DONE
    |-> (prdata[5:0] & src.onSeqBusy) == 6'h0) else $error("enable done set while busy");
  a_pin_mask: assert property (calm && idx == `IRQR_IDX_PIN_LEVEL
    |-> prdata == {16'h0, src.pinLevel & src.pinIsGpioIn}) else $error("pin levels wrong");
  a_fifo_nonempty: assert property (calm && idx == `IRQR_IDX_EV_NONEMPTY
    |-> prdata == {31'h0, src.evlogLevel != 5'h0}) else $error("not empty flag wrong");
  a_fifo_full: assert property (calm && idx == `IRQR_IDX_EV_FULL
    |-> prdata == {31'h0, src.evlogLevel >= `IRQR_EVLOG_DEPTH}) else $error("full flag wrong");
  a_dma_done: assert property (calm && idx == `IRQR_IDX_DMA_DONE
    |-> prdata == {31'h0, dmaAll}) else $error("dma flag wrong");
  a_upper_zero: assert property (rd && idx >= `IRQR_IDX_SHORT && idx <= `IRQR_IDX_DSP_ACT
    |-> prdata[31:16] == 16'h0) else $error("reserved bits set");
  a_write_ok: assert property (psel && penable && pwrite && paddr == {`IRQR_IDX_SHORT, 2'h0}
    |-> pready && !pslverr) else $error("status write refused");
  c_short: cover property (calm && idx == `IRQR_IDX_SHORT && prdata != 32'h0);
  c_full: cover property (calm && idx == `IRQR_IDX_EV_FULL && prdata[0]);
  c_error: cover property (psel && penable && pslverr);
  c_wmark_write: cover property (psel && penable && pwrite && idx == `IRQR_IDX_WMARK_CFG && pwdata[4:0] == 5'h10);
endmodule

// ### bench/test_irqr_status_bank.sv
/*
  Self-checking bench of the raw status bank over APB and its source inputs.
  Assumes the package, map header and design compiled before it.
*/
`timescale 1ns/10ps
`include "irqr_map.svh"

module test_irqr_status_bank;
  import irqr_pkg::*;
  localparam logic [15:0] A_SHORT = {`IRQR_IDX_SHORT, 2'h0};
  localparam logic [15:0] A_ON = {`IRQR_IDX_ON_DONE, 2'h0};
  localparam logic [15:0] A_OFF = {`IRQR_IDX_OFF_DONE, 2'h0};
  localparam logic [15:0] A_PIN = {`IRQR_IDX_PIN_LEVEL, 2'h0};
  localparam logic [15:0] A_NE = {`IRQR_IDX_EV_NONEMPTY, 2'h0};
  localparam logic [15:0] A_FULL = {`IRQR_IDX_EV_FULL, 2'h0};
  localparam logic [15:0] A_WM = {`IRQR_IDX_EV_WMARK, 2'h0};
  localparam logic [15:0] A_DMA = {`IRQR_IDX_DMA_DONE, 2'h0};
  localparam logic [15:0] A_DSP = {`IRQR_IDX_DSP_ACT, 2'h0};
  localparam logic [15:0] A_CFG = {`IRQR_IDX_WMARK_CFG, 2'h0};
  localparam logic [15:0] REGS [9] = '{A_SHORT, A_ON, A_OFF, A_PIN, A_NE, A_FULL, A_WM, A_DMA, A_DSP};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  irqr_src_s src = '0;
  logic [31:0] rdat;
  logic rerr;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  irqr_status_bank irqr_status_bank_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src(src));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end
  // ------
  // Shared tasks
  // ------
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  // Leaves the bus in its access phase so that a transfer may follow at once.
  task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] addr, input logic [31:0] want, input logic err);
    apb(1'b0, addr, 32'h0);
    check(rdat, want);
    check({31'h0, rerr}, {31'h0, err});
  endtask
  task automatic setSeq(input int k, input logic [5:0] v);
    if (k == 0) src.onSeqBusy <= v;
    else src.offSeqBusy <= v;
    idle();
  endtask
  task automatic dma(input logic [31:0] v, input logic want);
    {src.wdmaEnable, src.wdmaFilled, src.rdmaEnable, src.rdmaEmptied} <= v;
    idle();
    rd(A_DMA, {31'h0, want}, 1'b0);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    foreach (REGS[i]) rd(REGS[i], 32'h0, 1'b0);
    rd(A_CFG, {27'h0, `IRQR_WMARK_RST}, 1'b0);
  endtask
  task automatic t_short();
    for (int i = 0; i < 8; i++) begin
      src.shortDetect <= 8'h1 << i;
      idle();
      rd(A_SHORT, 32'h1 << (i < 6 ? i : i + 2), 1'b0);
    end
    src.shortDetect <= 8'h0;
    idle();
    rd(A_SHORT, 32'h0, 1'b0);
  endtask
  task automatic t_seq();
    for (int k = 0; k < 2; k++) begin
      setSeq(k, 6'h15);
      rd(k ? A_OFF : A_ON, 32'h0, 1'b0);
      setSeq(k, 6'h00);
      rd(k ? A_OFF : A_ON, 32'h15, 1'b0);
      setSeq(k, 6'h3f);
      setSeq(k, 6'h30);
      rd(k ? A_OFF : A_ON, 32'h0f, 1'b0);
      setSeq(k, 6'h00);
      rd(k ? A_OFF : A_ON, 32'h3f, 1'b0);
    end
  endtask
  task automatic t_pins();
    src.pinLevel <= 16'hffff;
    src.pinIsGpioIn <= 16'h8001;
    idle();
    rd(A_PIN, 32'h8001, 1'b0);
    src.pinLevel <= 16'h7ffe;
    src.pinIsGpioIn <= 16'hffff;
    idle();
    rd(A_PIN, 32'h7ffe, 1'b0);
  endtask
  task automatic t_evlog();
    logic [4:0] lv [6] = '{5'h0, 5'h1, 5'h7, 5'h8, 5'hf, 5'h10};
    logic [4:0] wm;
    for (int w = 0; w < 2; w++) begin
      wm = w ? 5'h10 : `IRQR_WMARK_RST;
      apb(1'b1, A_CFG, {27'h0, wm});
      foreach (lv[i]) begin
        src.evlogLevel <= lv[i];
        idle();
        rd(A_NE, {31'h0, lv[i] != 5'h0}, 1'b0);
        rd(A_FULL, {31'h0, lv[i] >= `IRQR_EVLOG_DEPTH}, 1'b0);
        rd(A_WM, {31'h0, lv[i] >= wm}, 1'b0);
      end
    end
  endtask
  task automatic t_dma();
    dma(32'h00000000, 1'b0);
    dma(32'h01000000, 1'b0);
    dma(32'h01030000, 1'b1);
    dma(32'h01038000, 1'b0);
    dma(32'h01038080, 1'b1);
    dma(32'h00008040, 1'b0);
    src.dspBusy <= 1'b1;
    idle();
    rd(A_DSP, 32'h1, 1'b0);
  endtask
  task automatic t_ro();
    src.shortDetect <= 8'h81;
    idle();
    foreach (REGS[i]) begin
      apb(1'b1, REGS[i], 32'hffffffff);
      check({31'h0, rerr}, 32'h0);
    end
    rd(A_SHORT, 32'h201, 1'b0);
    rd(A_PIN, 32'h7ffe, 1'b0);
    rd(16'h6238, 32'h0, 1'b1);
    rd(16'h622d, 32'h0, 1'b1);
    idle();
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_short();
    t_seq();
    t_pins();
    t_evlog();
    t_dma();
    t_ro();
    end_of_test();
  end
endmodule

bind irqr_status_bank irqr_status_bank_props irqr_status_bank_props_inst (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src(src));

// ### shared/irqr_map.svh
/*
  Register indices, field layouts and reset values of the raw status bank.
  Assumes it is included by its bare name; holds definitions only.
*/
`ifndef IRQR_MAP_SVH
`define IRQR_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index).
// ----------------------------------------------------------------------------
`define IRQR_IDX_SHORT 14'h188b
`define IRQR_IDX_ON_DONE 14'h188c
`define IRQR_IDX_OFF_DONE 14'h188d
`define IRQR_IDX_PIN_LEVEL 14'h1890
`define IRQR_IDX_EV_NONEMPTY 14'h1895
`define IRQR_IDX_EV_FULL 14'h1896
`define IRQR_IDX_EV_WMARK 14'h1897
`define IRQR_IDX_DMA_DONE 14'h1898
`define IRQR_IDX_DSP_ACT 14'h189d
`define IRQR_IDX_WMARK_CFG 14'h18c0

// ----------------------------------------------------------------------------
// Field positions and widths.
// ----------------------------------------------------------------------------
`define IRQR_SHORT_LOW_LSB 0
`define IRQR_SHORT_LOW_MSB 5
`define IRQR_SHORT_OUT4L_BIT 8
`define IRQR_SHORT_OUT4R_BIT 9
`define IRQR_SEQ_CHANNELS 6
`define IRQR_FLAG_BIT 0
`define IRQR_ADDR_LSB 2

// ----------------------------------------------------------------------------
// Reset values and sizes.
// ----------------------------------------------------------------------------
`define IRQR_STATUS_RST 16'h0000
`define IRQR_WMARK_RST 5'h08
`define IRQR_EVLOG_DEPTH 5'h10

`endif

// ### shared/irqr_pkg.sv
/*
  Types shared by the raw status bank and its bus slave.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package irqr_pkg;

  // --------------------------------------------------------------------------
  // Sequence tracking state of one output channel.
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_UNKNOWN,
    SEQ_RUN,
    SEQ_DONE
  } irqr_seq_e;

  // --------------------------------------------------------------------------
  // Conditions driven by the source units.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] shortDetect;
    logic [5:0] onSeqBusy;
    logic [5:0] offSeqBusy;
    logic [15:0] pinLevel;
    logic [15:0] pinIsGpioIn;
    logic [4:0] evlogLevel;
    logic [7:0] wdmaEnable;
    logic [7:0] wdmaFilled;
    logic [7:0] rdmaEnable;
    logic [7:0] rdmaEmptied;
    logic dspBusy;
  } irqr_src_s;

  // --------------------------------------------------------------------------
  // Register access from the bus slave and its answer.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [13:0] index;
    logic [31:0] wdata;
  } irqr_bus_s;

  typedef struct packed {
    logic hit;
    logic [31:0] rdata;
  } irqr_ans_s;

endpackage

// ### src/irqr_apb_slave.sv
/*
  APB slave front end of the raw status bank.
  Assumes an APB master on clk and a register file that answers combinationally.
*/
`timescale 1ns/10ps
`include "irqr_map.svh"

module irqr_apb_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output irqr_pkg::irqr_bus_s busReq,
  input wire irqr_pkg::irqr_ans_s busAns
);
  import irqr_pkg::*;

  logic aligned;
  logic setupPhase;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  // --------------------------------------------------------------------------
  // Request decode.
  // --------------------------------------------------------------------------
  assign aligned = (paddr[1:0] == 2'h0);
  assign setupPhase = psel & ~penable;
  assign pready = psel & penable;

  always_comb begin
    busReq.index = paddr[15:`IRQR_ADDR_LSB];
    busReq.wdata = pwdata;
    busReq.rd = setupPhase & ~pwrite & aligned;
    busReq.wr = psel & penable & pwrite & aligned;
  end

  // --------------------------------------------------------------------------
  // Answer captured in the setup cycle, shown in the access cycle.
  // --------------------------------------------------------------------------
  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setupPhase) begin
      prdata_nxt = (busReq.rd & busAns.hit) ? busAns.rdata : 32'h0;
      pslverr_nxt = ~(aligned & busAns.hit);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r & pready;

endmodule

// ### src/irqr_status_bank.sv
/*
  Raw status bank of the first interrupt controller: short circuit, output
  sequence, pin level, event log, DSP DMA and DSP activity flags, read over APB.
  Assumes source conditions synchronous to clk and an APB master on clk.
*/
`timescale 1ns/10ps
`include "irqr_map.svh"

// Overview of operation
// RQ1: Eight short flags sit at bits 0 to 5 for outputs one to three and bits 8 and 9 for output four.
// RQ2: A short flag reads 1 while its channel shows a short and 0 otherwise.
// RQ3: An enable-done flag reads 0 while its enable sequence runs and 1 once it has finished.
// RQ4: Enable-done flags sit at bits 0 to 5, with bits 4 and 5 shared by outputs three and four.
// RQ5: Disable-done flags use the same bits and read 0 while running and 1 once complete.
// RQ6: Levels of pins one to sixteen are returned in one register, pin n at bit n minus one.
// RQ7: A pin level is reported only for pins set up as general inputs; others read 0.
// RQ8: Bit 0 of one register reads 1 while the event log holds entries.
// RQ9: Bit 0 of a separate register reads 1 while the event log is full.
// RQ10: Bit 0 of its own register reads 1 once the event log level reaches the watermark.
// RQ11: The DMA flag reads 1 only when all enabled write buffers are filled and read buffers emptied.
// RQ12: Status registers are read-only, follow their sources, ignore writes and read 0 in reserved bits.
// RQ13: Every status flag reads 0 after reset until its source drives a new condition.
module irqr_status_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire irqr_pkg::irqr_src_s src
);
  import irqr_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations.
  // --------------------------------------------------------------------------
  irqr_bus_s busReq;
  irqr_ans_s busAns;

  logic [7:0] shortFlag_r;
  logic [7:0] shortFlag_nxt;

  irqr_seq_e onState_r [`IRQR_SEQ_CHANNELS];
  irqr_seq_e onState_nxt [`IRQR_SEQ_CHANNELS];
  irqr_seq_e offState_r [`IRQR_SEQ_CHANNELS];
  irqr_seq_e offState_nxt [`IRQR_SEQ_CHANNELS];
  logic [5:0] onDone;
  logic [5:0] offDone;

  logic [15:0] pinLevel_r;
  logic [15:0] pinLevel_nxt;

  logic [4:0] wmark_r;
  logic [4:0] wmark_nxt;
  logic evNonEmpty_r;
  logic evNonEmpty_nxt;
  logic evFull_r;
  logic evFull_nxt;
  logic evWmark_r;
  logic evWmark_nxt;

  logic dmaDone_r;
  logic dmaDone_nxt;
  logic dspBusy_r;
  logic dspBusy_nxt;

  // --------------------------------------------------------------------------
  // Helper functions.
  // --------------------------------------------------------------------------
  function automatic irqr_seq_e seqStep(input irqr_seq_e cur, input logic busy);
    irqr_seq_e nxt;
    nxt = cur;
    unique case (cur)
      SEQ_UNKNOWN: begin
        if (busy) begin
          nxt = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (!busy) begin
          nxt = SEQ_DONE;
        end
      end
      SEQ_DONE: begin
        if (busy) begin
          nxt = SEQ_RUN;
        end
      end
      default: begin
        nxt = SEQ_UNKNOWN;
      end
    endcase
    return nxt;
  endfunction

  function automatic logic [15:0] flagWord(input logic flag);
    logic [15:0] w;
    w = `IRQR_STATUS_RST;
    w[`IRQR_FLAG_BIT] = flag;
    return w;
  endfunction

  function automatic logic allServed(input logic [7:0] en, input logic [7:0] done);
    return &(~en | done);
  endfunction

  // --------------------------------------------------------------------------
  // Bus slave.
  // --------------------------------------------------------------------------
  irqr_apb_slave irqr_apb_slave_inst (
    .clk(clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .busReq(busReq),
    .busAns(busAns)
  );

  // --------------------------------------------------------------------------
  // Short circuit flags.
  // --------------------------------------------------------------------------
  always_comb begin
    shortFlag_nxt = src.shortDetect; // RQ2
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shortFlag_r <= 8'h00; // RQ13
    end else begin
      shortFlag_r <= shortFlag_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Output enable and disable sequence tracking.
  // --------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `IRQR_SEQ_CHANNELS; i++) begin
      onState_nxt[i] = seqStep(onState_r[i], src.onSeqBusy[i]); // RQ3
      offState_nxt[i] = seqStep(offState_r[i], src.offSeqBusy[i]); // RQ5
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `IRQR_SEQ_CHANNELS; i++) begin
        onState_r[i] <= SEQ_UNKNOWN; // RQ13
        offState_r[i] <= SEQ_UNKNOWN;
      end
    end else begin
      for (int i = 0; i < `IRQR_SEQ_CHANNELS; i++) begin
        onState_r[i] <= onState_nxt[i];
        offState_r[i] <= offState_nxt[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `IRQR_SEQ_CHANNELS; i++) begin
      onDone[i] = (onState_r[i] == SEQ_DONE); // RQ3
      offDone[i] = (offState_r[i] == SEQ_DONE); // RQ5
    end
  end

  // --------------------------------------------------------------------------
  // Pin levels.
  // --------------------------------------------------------------------------
  always_comb begin
    pinLevel_nxt = src.pinLevel & src.pinIsGpioIn; // RQ7
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinLevel_r <= `IRQR_STATUS_RST; // RQ13
    end else begin
      pinLevel_r <= pinLevel_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Watermark setting.
  // --------------------------------------------------------------------------
  always_comb begin
    wmark_nxt = wmark_r;
    if (busReq.wr && busReq.index == `IRQR_IDX_WMARK_CFG) begin
      wmark_nxt = busReq.wdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wmark_r <= `IRQR_WMARK_RST;
    end else begin
      wmark_r <= wmark_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Event log flags.
  // --------------------------------------------------------------------------
  always_comb begin
    evNonEmpty_nxt = (src.evlogLevel != 5'h00); // RQ8
    evFull_nxt = (src.evlogLevel >= `IRQR_EVLOG_DEPTH); // RQ9
    evWmark_nxt = (src.evlogLevel >= wmark_r); // RQ10
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evNonEmpty_r <= 1'b0; // RQ13
      evFull_r <= 1'b0;
      evWmark_r <= 1'b0;
    end else begin
      evNonEmpty_r <= evNonEmpty_nxt;
      evFull_r <= evFull_nxt;
      evWmark_r <= evWmark_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // DSP DMA flag.
  // --------------------------------------------------------------------------
  always_comb begin
    dmaDone_nxt = allServed(src.wdmaEnable, src.wdmaFilled)
                  & allServed(src.rdmaEnable, src.rdmaEmptied)
                  & (|{src.wdmaEnable, src.rdmaEnable}); // RQ11
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dmaDone_r <= 1'b0; // RQ13
    end else begin
      dmaDone_r <= dmaDone_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // DSP activity flag.
  // --------------------------------------------------------------------------
  always_comb begin
    dspBusy_nxt = src.dspBusy;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dspBusy_r <= 1'b0;
    end else begin
      dspBusy_r <= dspBusy_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Read decode; status registers ignore writes.
  // --------------------------------------------------------------------------
  always_comb begin
    busAns.hit = 1'b1;
    busAns.rdata = 32'h0;
    unique case (busReq.index)
      `IRQR_IDX_SHORT: begin
        busAns.rdata[`IRQR_SHORT_LOW_MSB:`IRQR_SHORT_LOW_LSB] = shortFlag_r[5:0]; // RQ1
        busAns.rdata[`IRQR_SHORT_OUT4L_BIT] = shortFlag_r[6];
        busAns.rdata[`IRQR_SHORT_OUT4R_BIT] = shortFlag_r[7];
      end
      `IRQR_IDX_ON_DONE: begin
        busAns.rdata[5:0] = onDone; // RQ4
      end
      `IRQR_IDX_OFF_DONE: begin
        busAns.rdata[5:0] = offDone; // RQ5
      end
      `IRQR_IDX_PIN_LEVEL: begin
        busAns.rdata[15:0] = pinLevel_r; // RQ6
      end
      `IRQR_IDX_EV_NONEMPTY: begin
        busAns.rdata[15:0] = flagWord(evNonEmpty_r); // RQ8
      end
      `IRQR_IDX_EV_FULL: begin
        busAns.rdata[15:0] = flagWord(evFull_r); // RQ9
      end
      `IRQR_IDX_EV_WMARK: begin
        busAns.rdata[15:0] = flagWord(evWmark_r); // RQ10
      end
      `IRQR_IDX_DMA_DONE: begin
        busAns.rdata[15:0] = flagWord(dmaDone_r); // RQ11
      end
      `IRQR_IDX_DSP_ACT: begin
        busAns.rdata[15:0] = flagWord(dspBusy_r);
      end
      `IRQR_IDX_WMARK_CFG: begin
        busAns.rdata[4:0] = wmark_r;
      end
      default: begin
        busAns.hit = 1'b0; // RQ12
      end
    endcase
  end

endmodule
